// *** hw/acc_pkg.sv ***
// Purpose: Shared constants and types for the calibration control block
// Assumes: 8-bit register addresses and data
// Notes:   Vector length fixed by the converter core count
package acc_pkg;
    localparam logic [7:0] ADR_RUN      = 8'h61;
    localparam logic [7:0] ADR_CFG      = 8'h62;
    localparam logic [7:0] ADR_STATE    = 8'h6a;
    localparam logic [7:0] ADR_PIN      = 8'h6b;
    localparam logic [7:0] ADR_SOFT     = 8'h6c;
    localparam logic [7:0] ADR_CEN      = 8'h70;
    localparam logic [7:0] ADR_DATA     = 8'h71;
    localparam int         VEC_LEN      = 673;
    localparam logic [9:0] VEC_LAST     = 10'h2a0;
    localparam logic [9:0] PTR_ZERO     = 10'h000;
    localparam logic [9:0] PTR_ONE      = 10'h001;
    localparam logic [7:0] RST_RUN      = 8'h01;
    localparam logic [7:0] RST_CFG      = 8'h01;
    localparam logic [7:0] RST_PIN      = 8'h00;
    localparam logic [7:0] RST_SOFT     = 8'h01;
    localparam logic [7:0] RST_CEN      = 8'h00;
    localparam logic [7:0] ZERO8        = 8'h00;
    localparam int         TRIG_BIT     = 0;
    localparam int         SEL_LO       = 1;
    localparam int         SEL_HI       = 2;
    localparam logic [1:0] SEL_FG       = 2'h0;
    localparam logic [1:0] SEL_HALT     = 2'h1;
    localparam logic [1:0] SEL_ALARM    = 2'h2;
    // Last foreground count before halt; the run lasts one cycle more, model figure
    localparam logic [7:0] FG_CYCLES    = 8'h40;
    localparam logic [2:0] CODE_IDLE    = 3'h0;
    localparam logic [2:0] CODE_CLEAR   = 3'h1;
    localparam logic [2:0] CODE_FG      = 3'h2;
    localparam logic [2:0] CODE_HALT    = 3'h3;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'h1,
        ST_CLEAR = 4'h2,
        ST_FG    = 4'h4,
        ST_HALT  = 4'h8
    } acc_state_type;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } acc_req_type;
endpackage : acc_pkg

// *** hw/acc_ctrl.sv ***
// Purpose: Calibration status, trigger and coefficient access registers
// Assumes: One register request per cycle; read data one cycle later
// Notes:   Calibration engine is a behavioural stand-in for the cores
//
// How it works
// - Halted flag set once foreground calibration finished or skipped.
// - Foreground-finished flag high on completion, and also when skipped.
// - Status register read-only: code, halted and finished flags.
// - Status pin select: 0 finished, 1 halted, 2 alarm, 3 low.
// - Select bit 0: software trigger bit used, trigger pin ignored.
// - Select bit 1: trigger pin used, software trigger bit ignored.
// - Coefficient port reads and writes only while access enable set.
// - Successive reads return consecutive values; 673 give whole vector.
// - Run enable runs calibration; clear holds it and resets dividers.
// - Start clears values, then skips or runs foreground per config bit 0.
`timescale 1ns/10ps
`default_nettype none
module acc_ctrl
    import acc_pkg::*;
(
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        nrst,
    // Register port
    input  wire acc_req_type req,
    output var  logic [7:0]  rdata_r,
    // Pins
    input  wire logic        trigger_input_pin,
    input  wire logic        alarm,
    output var  logic        status_output_pin_r,
    output var  logic        div_reset_r
);
    acc_state_type st_r, st_nxt;
    logic [7:0] run_r, run_nxt, cfg_r, cfg_nxt, pin_r, pin_nxt;
    logic [7:0] soft_r, soft_nxt, cen_r, cen_nxt, rdata_nxt;
    logic [9:0] ptr_r, ptr_nxt, clr_r, clr_nxt;
    logic [7:0] fgc_r, fgc_nxt;
    logic       halted_r, halted_nxt, fgdone_r, fgdone_nxt;
    logic       spin_nxt, div_nxt, trig;
    logic [7:0] vec_r [VEC_LEN];
    logic       mem_we;
    logic [9:0] mem_idx;
    logic [7:0] mem_wd;
    logic       hit_data;
    logic [2:0] code;

    function automatic logic [9:0] ptr_step(input logic [9:0] p);
        ptr_step = (p == VEC_LAST) ? PTR_ZERO : p + PTR_ONE;
    endfunction : ptr_step

    function automatic logic pin_mux(input logic [1:0] s,
                                     input logic f, input logic h,
                                     input logic a);
        case (s)
            SEL_FG:    pin_mux = f;
            SEL_HALT:  pin_mux = h;
            SEL_ALARM: pin_mux = a;
            default:   pin_mux = 1'b0;
        endcase
    endfunction : pin_mux

    // Register writes
    always_comb begin
        run_nxt  = run_r;
        cfg_nxt  = cfg_r;
        pin_nxt  = pin_r;
        soft_nxt = soft_r;
        cen_nxt  = cen_r;
        if (req.wr) begin
            case (req.addr)
                ADR_RUN:  run_nxt  = req.wdata;
                ADR_CFG:  cfg_nxt  = req.wdata;
                ADR_PIN:  pin_nxt  = req.wdata;
                ADR_SOFT: soft_nxt = req.wdata;
                ADR_CEN:  cen_nxt  = req.wdata;
                default:  ;
            endcase
        end
    end

    // Trigger source
    assign trig = pin_r[TRIG_BIT] ? trigger_input_pin
                                  : soft_r[TRIG_BIT];

    // Calibration sequence
    always_comb begin
        st_nxt     = st_r;
        clr_nxt    = clr_r;
        fgc_nxt    = fgc_r;
        halted_nxt = halted_r;
        fgdone_nxt = fgdone_r;
        div_nxt    = ~run_r[0];
        case (st_r)
            ST_IDLE: begin
                halted_nxt = 1'b0;
                fgdone_nxt = 1'b0;
                if (run_r[0] && trig) begin
                    st_nxt  = ST_CLEAR;
                    clr_nxt = PTR_ZERO;
                end
            end
            ST_CLEAR: begin
                clr_nxt = clr_r + PTR_ONE;
                if (clr_r == VEC_LAST) begin
                    if (cfg_r[0]) begin
                        st_nxt  = ST_FG;
                        fgc_nxt = ZERO8;
                    end else begin
                        st_nxt     = ST_HALT;
                        halted_nxt = 1'b1;
                        fgdone_nxt = 1'b1;
                    end
                end
            end
            ST_FG: begin
                fgc_nxt = fgc_r + 8'h01;
                if (fgc_r == FG_CYCLES) begin
                    st_nxt     = ST_HALT;
                    halted_nxt = 1'b1;
                    fgdone_nxt = 1'b1;
                end
            end
            ST_HALT: ;
            default: st_nxt = ST_IDLE;
        endcase
        if (!run_r[0]) begin
            st_nxt     = ST_IDLE;
            halted_nxt = 1'b0;
            fgdone_nxt = 1'b0;
        end
    end

    always_comb begin
        case (st_r)
            ST_CLEAR: code = CODE_CLEAR;
            ST_FG:    code = CODE_FG;
            ST_HALT:  code = CODE_HALT;
            default:  code = CODE_IDLE;
        endcase
    end

    // Coefficient port and read data
    assign hit_data = (req.addr == ADR_DATA) && cen_r[0];
    always_comb begin
        ptr_nxt   = ptr_r;
        mem_we    = 1'b0;
        mem_idx   = ptr_r;
        mem_wd    = req.wdata;
        rdata_nxt = rdata_r;
        if (st_r == ST_CLEAR) begin
            mem_we  = 1'b1;
            mem_idx = clr_r;
            mem_wd  = ZERO8;
        end else if (req.wr && hit_data) begin
            mem_we  = 1'b1;
            ptr_nxt = ptr_step(ptr_r);
        end
        if (req.rd) begin
            case (req.addr)
                ADR_STATE: rdata_nxt = {3'h0, code, halted_r, fgdone_r};
                ADR_RUN:   rdata_nxt = run_r;
                ADR_CFG:   rdata_nxt = cfg_r;
                ADR_PIN:   rdata_nxt = pin_r;
                ADR_SOFT:  rdata_nxt = soft_r;
                ADR_CEN:   rdata_nxt = cen_r;
                ADR_DATA:  rdata_nxt = cen_r[0] ? vec_r[ptr_r] : ZERO8;
                default:   rdata_nxt = ZERO8;
            endcase
            if (hit_data)
                ptr_nxt = ptr_step(ptr_r);
        end
        if (cen_nxt[0] && !cen_r[0])
            ptr_nxt = PTR_ZERO;
    end

    assign spin_nxt = pin_mux(pin_r[SEL_HI:SEL_LO], fgdone_r, halted_r, alarm);

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            st_r                <= ST_IDLE;
            run_r               <= RST_RUN;
            cfg_r               <= RST_CFG;
            pin_r               <= RST_PIN;
            soft_r              <= RST_SOFT;
            cen_r               <= RST_CEN;
            ptr_r               <= PTR_ZERO;
            clr_r               <= PTR_ZERO;
            fgc_r               <= ZERO8;
            halted_r            <= 1'b0;
            fgdone_r            <= 1'b0;
            rdata_r             <= ZERO8;
            status_output_pin_r <= 1'b0;
            div_reset_r         <= 1'b0;
        end else begin
            st_r                <= st_nxt;
            run_r               <= run_nxt;
            cfg_r               <= cfg_nxt;
            pin_r               <= pin_nxt;
            soft_r              <= soft_nxt;
            cen_r               <= cen_nxt;
            ptr_r               <= ptr_nxt;
            clr_r               <= clr_nxt;
            fgc_r               <= fgc_nxt;
            halted_r            <= halted_nxt;
            fgdone_r            <= fgdone_nxt;
            rdata_r             <= rdata_nxt;
            status_output_pin_r <= spin_nxt;
            div_reset_r         <= div_nxt;
        end
    end

    always_ff @(posedge mclk) begin
        if (mem_we)
            vec_r[mem_idx] <= mem_wd;
    end

    // Checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    sequence clear_end_s;
        st_r == ST_CLEAR && clr_r == VEC_LAST && run_r[0];
    endsequence

    sequence start_s;
        st_r == ST_IDLE && run_r[0] && trig;
    endsequence

    sequence fg_end_s;
        st_r == ST_FG && fgc_r == FG_CYCLES && run_r[0];
    endsequence

    skip_halt_a: assert property (clear_end_s and !cfg_r[0] |=> halted_r && fgdone_r)
        else $error("skip did not halt");
    foreground_finished_flag_a: assert property (st_r == ST_FG && fgc_r == FG_CYCLES && run_r[0]
                                |=> fgdone_r && st_r == ST_HALT)
        else $error("foreground end not flagged");
    status_read_a: assert property (req.rd && req.addr == ADR_STATE
                                    |=> rdata_r == {3'h0, $past(code), $past(halted_r), $past(fgdone_r)})
        else $error("status read mismatch");
    pin_follow_a: assert property (##1 status_output_pin_r == pin_mux($past(pin_r[SEL_HI:SEL_LO]),
                                   $past(fgdone_r), $past(halted_r), $past(alarm)))
        else $error("status pin wrong");
    soft_trig_a: assert property (st_r == ST_IDLE && !pin_r[TRIG_BIT] && !soft_r[TRIG_BIT]
                                  |=> st_r == ST_IDLE)
        else $error("pin started in soft mode");
    hw_trig_a: assert property (st_r == ST_IDLE && pin_r[TRIG_BIT] && !trigger_input_pin
                                |=> st_r == ST_IDLE)
        else $error("soft bit started in hw mode");
    port_gate_a: assert property (req.rd && req.addr == ADR_DATA && !cen_r[0]
                                  |=> rdata_r == ZERO8 && ptr_r == $past(ptr_r))
        else $error("port open while disabled");
    ptr_step_a: assert property (req.rd && hit_data && !req.wr && !(cen_nxt[0] && !cen_r[0])
                                 |=> ptr_r == ptr_step($past(ptr_r)))
        else $error("pointer not stepped");
    run_hold_a: assert property (!run_r[0] |=> st_r == ST_IDLE && !halted_r ##0 div_reset_r)
        else $error("hold not applied");
    start_clear_a: assert property (st_r == ST_IDLE && run_r[0] && trig
                                    |=> st_r == ST_CLEAR ##1 clr_r == PTR_ONE || st_r == ST_IDLE)
        else $error("start did not clear");
    rewind_a: assert property (req.wr && req.addr == ADR_CEN && req.wdata[0] && !cen_r[0]
                               |=> ptr_r == PTR_ZERO)
        else $error("pointer not rewound");
    fg_run_a: assert property (clear_end_s and cfg_r[0]
                               |=> st_r == ST_FG && fgc_r == ZERO8)
        else $error("foreground not entered");
    skip_fg_a: assert property (clear_end_s and !cfg_r[0]
                                |=> st_r == ST_HALT)
        else $error("foreground not skipped");
    fg_halt_a: assert property (fg_end_s
                                |=> halted_r && st_r == ST_HALT)
        else $error("foreground end did not halt");
    halt_hold_a: assert property (st_r == ST_HALT && run_r[0]
                                  |=> st_r == ST_HALT && halted_r && fgdone_r)
        else $error("halted state lost");
    start_code_a: assert property (start_s
                                   |=> st_r == ST_CLEAR && clr_r == PTR_ZERO)
        else $error("clear not started at first value");
    clear_zero_a: assert property (st_r == ST_CLEAR
                                   |=> vec_r[$past(clr_r)] == ZERO8)
        else $error("value not cleared");
    idle_trig_a: assert property (st_r == ST_IDLE && run_r[0] && !pin_r[TRIG_BIT] && soft_r[TRIG_BIT]
                                  |=> st_r == ST_CLEAR)
        else $error("soft trigger ignored");
    hw_start_a: assert property (st_r == ST_IDLE && run_r[0] && pin_r[TRIG_BIT] && trigger_input_pin
                                 |=> st_r == ST_CLEAR)
        else $error("pin trigger ignored");
    low_pin_a: assert property (pin_r[SEL_HI] && pin_r[SEL_LO]
                                |=> !status_output_pin_r)
        else $error("status pin not held low");
    div_follow_a: assert property (##1 div_reset_r == !$past(run_r[0]))
        else $error("divider reset not following run");
    ptr_wrap_a: assert property (req.rd && hit_data && ptr_r == VEC_LAST
                                 |=> ptr_r == PTR_ZERO)
        else $error("pointer did not wrap");
    write_store_a: assert property (req.wr && hit_data && st_r != ST_CLEAR
                                    |=> vec_r[$past(ptr_r)] == $past(req.wdata))
        else $error("port write not stored");
    write_gate_a: assert property (req.wr && req.addr == ADR_DATA && !cen_r[0]
                                   |=> ptr_r == $past(ptr_r))
        else $error("port write while disabled");
endmodule : acc_ctrl
`default_nettype wire

// *** tb/acc_host_pins.sv ***
// Purpose: Host-side driver of the trigger and alarm pins
// Assumes: Bench commands change on the falling clock edge
// Notes:   Pins move one falling edge after the command
`timescale 1ns/10ps
`default_nettype none
module acc_host_pins (
    // Clock
    input  wire logic mclk,
    // Commands from the bench
    input  wire logic trig_cmd,
    input  wire logic alarm_cmd,
    // Pins towards the device
    output var  logic trigger_input_pin,
    output var  logic alarm
);
    // Levels launched away from the sampling edge
    always @(negedge mclk) begin
        trigger_input_pin <= trig_cmd;
        alarm             <= alarm_cmd;
    end
endmodule : acc_host_pins
`default_nettype wire

// *** tb/acc_ctrl_tb.sv ***
// Purpose: Self-checking bench for the calibration control registers
// Assumes: Accesses launched on the falling edge, one at a time
// Notes:   Waits follow the clear and foreground run lengths
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin \
    $display("ERROR t=%0t got %h exp %h", $time, got, exp); n_fail++; end end
module acc_ctrl_tb
    import acc_pkg::*;
;
    logic        mclk;
    logic        nrst;
    acc_req_type req_s;
    logic [7:0]  rdata_r;
    logic        trig_cmd;
    logic        alarm_cmd;
    logic        trig_pin;
    logic        alarm_pin;
    logic        stat_pin;
    logic        div_rst;
    int          n_fail;
    int          n_tests;
    int          i;
    int          k;

    acc_ctrl dut_u (.mclk(mclk), .nrst(nrst), .req(req_s), .rdata_r(rdata_r), .trigger_input_pin(trig_pin),
                    .alarm(alarm_pin), .status_output_pin_r(stat_pin), .div_reset_r(div_rst));
    acc_host_pins host_u (.mclk(mclk), .trig_cmd(trig_cmd), .alarm_cmd(alarm_cmd),
                          .trigger_input_pin(trig_pin), .alarm(alarm_pin));

    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask : cyc

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk) req_s <= {1'b1, 1'b0, a, d};
        @(negedge mclk) req_s <= '0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge mclk) req_s <= {1'b0, 1'b1, a, 8'h00};
        @(negedge mclk) req_s <= '0;
        `CHK(rdata_r, e)
    endtask : rd

    // Streaming data port accesses, strobe held high throughout
    task automatic wr_burst(input int n, input logic [7:0] key);
        for (int j = 0; j < n; j++) begin
            @(negedge mclk) req_s <= {1'b1, 1'b0, ADR_DATA, 8'(j) ^ key};
        end
        @(negedge mclk) req_s <= '0;
    endtask : wr_burst

    task automatic rd_burst(input int n, input logic [7:0] key);
        @(negedge mclk) req_s <= {1'b0, 1'b1, ADR_DATA, 8'h00};
        for (int j = 0; j < n; j++) begin
            @(negedge mclk) if (j == n - 1) req_s <= '0;
            `CHK(rdata_r, 8'(j) ^ key)
        end
    endtask : rd_burst

    task automatic pin(input logic e);
        cyc(2);
        `CHK(stat_pin, e)
    endtask : pin

    task automatic test_done;
        $display("Checks %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : test_done

    // Watchdog well beyond the expected run of about 1.1 ms
    initial begin
        #3000000;
        n_fail++;
        test_done();
    end

    initial begin
        nrst = 1'b0;
        req_s = '0;
        trig_cmd = 1'b0;
        alarm_cmd = 1'b0;
        n_fail = 0;
        n_tests = 0;
        cyc(12);
        nrst = 1'b1;
        cyc(800);
        rd(ADR_STATE, 8'h0f);
        rd(ADR_PIN, RST_PIN);
        rd(ADR_SOFT, RST_SOFT);
        rd(ADR_CEN, RST_CEN);
        rd(ADR_DATA, ZERO8);
        rd(8'h50, ZERO8);
        wr(ADR_STATE, ZERO8);
        rd(ADR_STATE, 8'h0f);
        for (k = 0; k < 4; k++) begin
            wr(ADR_PIN, 8'(k * 2));
            pin(k < 2);
        end
        alarm_cmd <= 1'b1;
        pin(1'b0);
        wr(ADR_PIN, 8'h04);
        pin(1'b1);
        // Save-and-restore round trip with a known pattern
        wr(ADR_CEN, 8'h01);
        for (i = 0; i < VEC_LEN; i++) wr(ADR_DATA, 8'(i) ^ 8'h5a);
        wr(ADR_CEN, ZERO8);
        rd(ADR_DATA, ZERO8);
        wr(ADR_DATA, 8'hff);
        wr(ADR_CEN, 8'h01);
        for (i = 0; i < VEC_LEN; i++) rd(ADR_DATA, 8'(i) ^ 8'h5a);
        rd(ADR_DATA, 8'h5a);
        for (i = 1; i < VEC_LEN; i++) rd(ADR_DATA, 8'(i) ^ 8'h5a);
        wr(ADR_CEN, ZERO8);
        wr(ADR_CEN, 8'h01);
        wr_burst(VEC_LEN, 8'ha5);
        wr(ADR_CEN, ZERO8);
        wr(ADR_CEN, 8'h01);
        rd_burst(VEC_LEN, 8'ha5);
        wr(ADR_CEN, ZERO8);
        // Software trigger low, pin high: pin must be ignored
        wr(ADR_SOFT, ZERO8);
        wr(ADR_RUN, ZERO8);
        cyc(1);
        `CHK(div_rst, 1'b1)
        rd(ADR_STATE, ZERO8);
        trig_cmd <= 1'b1;
        wr(ADR_RUN, RST_RUN);
        cyc(800);
        rd(ADR_STATE, ZERO8);
        `CHK(div_rst, 1'b0)
        wr(ADR_SOFT, RST_SOFT);
        cyc(720);
        rd(ADR_STATE, 8'h08);
        cyc(80);
        rd(ADR_STATE, 8'h0f);
        // Pin as trigger, soft bit high must be ignored; skip foreground
        trig_cmd <= 1'b0;
        wr(ADR_PIN, 8'h01);
        wr(ADR_RUN, ZERO8);
        wr(ADR_CFG, ZERO8);
        wr(ADR_RUN, RST_RUN);
        cyc(800);
        rd(ADR_STATE, ZERO8);
        trig_cmd <= 1'b1;
        cyc(700);
        rd(ADR_STATE, 8'h0f);
        wr(ADR_CEN, 8'h01);
        for (i = 0; i < VEC_LEN; i++) rd(ADR_DATA, ZERO8);
        wr(ADR_CEN, ZERO8);
        test_done();
    end
endmodule : acc_ctrl_tb
`default_nettype wire
